// ===== rtl/fdo_drive_outputs.v
// Drive-side control outputs and DMA strobe qualification of the floppy controller
// Summary of operation
// - Density select shows high rate (500K, 1M) versus low rate (250K, 300K).
// - Configuration bit 5 inverts or keeps density select polarity.
// - During seek, direction active steps in, inactive steps out.
// - Direction held inactive during any read or write.
// - Two active-low drive selects follow digital output bits 0 and 1 once that register is first written.
// - Configuration bit 7 set encodes selects with motors for four drives.
// - Rate bit 0 follows bit 0 of the most recently written rate register.
// - Low DMA acknowledge makes read and write strobes transfer strobes.
// - Active-high DMA request tells host a transfer is needed.
`include "fdo_consts.vh"
module fdo_drive_outputs (
   input  wire       clk_sys,
   input  wire       reset_n,
   input  wire       dig_out_wr,
   input  wire [7:0] dig_out_wdata,
   input  wire       cfg_wr,
   input  wire [7:0] cfg_wdata,
   input  wire       cfg_ctl_wr,
   input  wire [1:0] cfg_ctl_rate,
   input  wire       rate_sel_wr,
   input  wire [1:0] rate_sel_rate,
   input  wire [1:0] op_state,
   input  wire       seek_inward,
   input  wire       xfer_needed,
   input  wire       dma_ack_n,
   input  wire       ior_n,
   input  wire       iow_n,
   output reg        density_select_out,
   output reg        head_dir_out,
   output reg  [1:0] drive_select_n,
   output reg  [1:0] motor_on_out,
   output reg        rate_bit0_out,
   output reg        dma_request,
   output reg        dma_read_strobe,
   output reg        dma_write_strobe
);
   // Host-written register images
   reg  [7:0] digital_output_reg;
   reg  [7:0] cfg_r;
   reg  [1:0] rate_r;
   reg        written_r;

   // Next values of the register images
   reg  [7:0] dout_nxt;
   reg  [7:0] cfg_nxt;
   reg  [1:0] rate_nxt;
   reg        written_nxt;

   // Next values of the registered outputs
   reg        dens_nxt;
   reg        dir_nxt;
   reg  [1:0] sel_nxt;
   reg  [1:0] motor_nxt;
   reg        rate0_nxt;
   reg        req_nxt;
   reg        rd_stb_nxt;
   reg        wr_stb_nxt;

   // Decoded register fields
   wire       dens_invert;
   wire       four_drive;
   wire [1:0] sel_field;
   wire [1:0] motor_pair;
   wire       any_motor;

   assign dens_invert = cfg_r[`FDO_CFG_DENS_POL_BIT];
   assign four_drive  = cfg_r[`FDO_CFG_FOUR_DRV_BIT];
   assign sel_field   = digital_output_reg[`FDO_DOUT_SEL_MSB:`FDO_DOUT_SEL_LSB];
   assign motor_pair  = {digital_output_reg[`FDO_DOUT_MOTOR1_BIT],
                         digital_output_reg[`FDO_DOUT_MOTOR0_BIT]};
   assign any_motor   = |digital_output_reg[`FDO_DOUT_MOTOR3_BIT:`FDO_DOUT_MOTOR0_BIT];

   // High rates are 500K and 1M; 250K and 300K are low
   function is_high_rate;
      input [1:0] rate;
      begin
         is_high_rate = (rate == `FDO_RATE_500K) || (rate == `FDO_RATE_1M);
      end
   endfunction

   // Normal mode decode; codes 2 and 3 select nothing
   function [1:0] normal_select_n;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: begin
               normal_select_n = 2'h2;
            end
            2'h1: begin
               normal_select_n = 2'h1;
            end
            default: begin
               normal_select_n = 2'h3;
            end
         endcase
      end
   endfunction

   // Encoded mode carries the drive number on the select pins
   function [1:0] encoded_select_n;
      input [1:0] sel;
      begin
         encoded_select_n = ~sel;
      end
   endfunction

   // A host strobe only counts while the acknowledge is low
   function qualify_strobe;
      input ack_n;
      input strobe_n;
      begin
         qualify_strobe = ~ack_n & ~strobe_n;
      end
   endfunction

   always @* begin
      dout_nxt    = digital_output_reg;
      written_nxt = written_r;
      if (dig_out_wr) begin
         dout_nxt    = dig_out_wdata;
         written_nxt = 1'b1;
      end
   end

   always @* begin
      cfg_nxt = cfg_r;
      if (cfg_wr) begin
         cfg_nxt = cfg_wdata;
      end
   end

   // Later of the two writes wins; same-cycle favours rate select
   always @* begin
      rate_nxt = rate_r;
      if (rate_sel_wr) begin
         rate_nxt = rate_sel_rate;
      end else if (cfg_ctl_wr) begin
         rate_nxt = cfg_ctl_rate;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         digital_output_reg <= `FDO_DOUT_RESET;
         written_r          <= 1'b0;
      end else begin
         digital_output_reg <= dout_nxt;
         written_r          <= written_nxt;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= `FDO_CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rate_r <= `FDO_RATE_RESET;
      end else begin
         rate_r <= rate_nxt;
      end
   end

   always @* begin
      dens_nxt = is_high_rate(rate_r) ^ dens_invert;
   end

   // Only a seek moves the head; reads and writes force inactive
   always @* begin
      dir_nxt = 1'b0;
      if (op_state == `FDO_OP_SEEK) begin
         dir_nxt = seek_inward;
      end
   end

   // Two pins only, so encoded mode folds all motors into one enable
   always @* begin
      sel_nxt   = `FDO_SEL_IDLE;
      motor_nxt = `FDO_MOTOR_IDLE;
      if (written_r) begin
         if (four_drive) begin
            sel_nxt   = encoded_select_n(sel_field);
            motor_nxt = {1'b0, any_motor};
         end else begin
            sel_nxt   = normal_select_n(sel_field);
            motor_nxt = motor_pair;
         end
      end
   end

   always @* begin
      rate0_nxt  = rate_r[0];
      req_nxt    = xfer_needed;
      rd_stb_nxt = qualify_strobe(dma_ack_n, ior_n);
      wr_stb_nxt = qualify_strobe(dma_ack_n, iow_n);
   end

   // Drive-side pins
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         density_select_out <= 1'b0;
         head_dir_out       <= 1'b0;
         drive_select_n     <= `FDO_SEL_IDLE;
         motor_on_out       <= `FDO_MOTOR_IDLE;
         rate_bit0_out      <= 1'b0;
      end else begin
         density_select_out <= dens_nxt;
         head_dir_out       <= dir_nxt;
         drive_select_n     <= sel_nxt;
         motor_on_out       <= motor_nxt;
         rate_bit0_out      <= rate0_nxt;
      end
   end

   // Host-side DMA pins
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dma_request      <= 1'b0;
         dma_read_strobe  <= 1'b0;
         dma_write_strobe <= 1'b0;
      end else begin
         dma_request      <= req_nxt;
         dma_read_strobe  <= rd_stb_nxt;
         dma_write_strobe <= wr_stb_nxt;
      end
   end
endmodule // fdo_drive_outputs

// ===== common/fdo_consts.vh
// Constants for the floppy drive control output block
`ifndef FDO_CONSTS_VH
`define FDO_CONSTS_VH
`define FDO_CFG_DENS_POL_BIT 5
`define FDO_CFG_FOUR_DRV_BIT 7
`define FDO_DOUT_SEL_LSB     0
`define FDO_DOUT_SEL_MSB     1
`define FDO_DOUT_MOTOR0_BIT  4
`define FDO_DOUT_MOTOR1_BIT  5
`define FDO_DOUT_MOTOR3_BIT  7
`define FDO_DOUT_RESET       8'h00
`define FDO_CFG_RESET        8'h00
`define FDO_RATE_RESET       2'h2
`define FDO_SEL_IDLE         2'h3
`define FDO_MOTOR_IDLE       2'h0
`define FDO_RATE_500K        2'h0
`define FDO_RATE_300K        2'h1
`define FDO_RATE_250K        2'h2
`define FDO_RATE_1M          2'h3
`define FDO_OP_IDLE          2'h0
`define FDO_OP_SEEK          2'h1
`define FDO_OP_READ          2'h2
`define FDO_OP_WRITE         2'h3
`endif

// ===== dv/fdo_checker.sv
// Port assertions for the drive output block
module fdo_checker (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       cfg_ctl_wr,
   input wire logic       rate_sel_wr,
   input wire logic       seek_inward,
   input wire logic       xfer_needed,
   input wire logic       dma_ack_n,
   input wire logic       ior_n,
   input wire logic       head_dir_out,
   input wire logic       rate_bit0_out,
   input wire logic       dma_request,
   input wire logic       dma_read_strobe,
   input wire logic       dma_write_strobe,
   input wire logic [1:0] cfg_ctl_rate,
   input wire logic [1:0] rate_sel_rate,
   input wire logic [1:0] op_state,
   input wire logic [1:0] drive_select_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_in; op_state == 2'h1 && seek_inward |=> head_dir_out; endproperty
   a_in: assert property (p_in) else $error("no step in");
   property p_rw; op_state[1] |=> !head_dir_out; endproperty
   a_rw: assert property (p_rw) else $error("dir active");
   property p_rd; !dma_ack_n && !ior_n |=> dma_read_strobe; endproperty
   a_rd: assert property (p_rd) else $error("no strobe");
   property p_idle; dma_ack_n |=> !dma_read_strobe && !dma_write_strobe; endproperty
   a_idle: assert property (p_idle) else $error("stray strobe");
   property p_req; xfer_needed |=> dma_request; endproperty
   a_req: assert property (p_req) else $error("no request");
   property p_rst; $rose(reset_n) |-> drive_select_n == 2'h3 && !head_dir_out; endproperty
   a_rst: assert property (p_rst) else $error("active at reset");
   property p_cctl;
      cfg_ctl_wr && !rate_sel_wr |=> ##1 rate_bit0_out == $past(cfg_ctl_rate[0], 2);
   endproperty
   a_cctl: assert property (p_cctl) else $error("rate bit");
   property p_rsel; rate_sel_wr |=> ##1 rate_bit0_out == $past(rate_sel_rate[0], 2); endproperty
   a_rsel: assert property (p_rsel) else $error("rate bit");
endmodule // fdo_checker
bind fdo_drive_outputs fdo_checker i_chk (.*);

// ===== dv/fdo_dma_host.sv
// Host DMA controller model, prompt or slow
module fdo_dma_host (
   input  wire logic clk_sys,
   input  wire logic dma_request,
   input  wire logic slow,
   input  wire logic rd,
   output logic      dma_ack_n = 1'b1,
   output logic      ior_n = 1'b1,
   output logic      iow_n = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   always @(posedge clk_sys) begin
      {dma_ack_n, ior_n, iow_n} <= 3'h7;
      n <= dma_request ? n + 1 : 0;
      if (dma_request && n >= (slow ? 3 : 0)) {dma_ack_n, ior_n, iow_n} <= {1'b0, !rd, rd};
   end
endmodule // fdo_dma_host

// ===== dv/fdo_drive_outputs_tb.sv
// Random self-checking bench for the drive output block
module fdo_drive_outputs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 0, reset_n = 0, ack_n, ior_n, iow_n, seen = 0;
   logic [15:0] r = 16'h003d;
   logic [9:0]  q, ex;
   logic [7:0]  dout = 0, cfg = 0;
   logic [1:0]  rate = 2'h2, s;
   int          err_total = 0, n_compared = 0;
   fdo_drive_outputs i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .dig_out_wr(r[0] & r[1]),
      .dig_out_wdata(r[15:8]), .cfg_wr(r[2] & r[3] & r[4]), .cfg_wdata(r[15:8]),
      .cfg_ctl_wr(r[5]), .cfg_ctl_rate(r[9:8]), .rate_sel_wr(r[6] & r[7]),
      .rate_sel_rate(r[11:10]), .op_state(r[13:12]),
      .seek_inward(r[14]), .xfer_needed(r[15]), .dma_ack_n(ack_n), .ior_n(ior_n),
      .iow_n(iow_n), .density_select_out(q[9]), .head_dir_out(q[8]), .drive_select_n(q[7:6]),
      .motor_on_out(q[5:4]), .rate_bit0_out(q[3]), .dma_request(q[2]),
      .dma_read_strobe(q[1]), .dma_write_strobe(q[0]));
   fdo_dma_host i_host (.clk_sys(clk_sys), .dma_request(q[2]), .slow(r[3]), .rd(r[4]),
      .dma_ack_n(ack_n), .ior_n(ior_n), .iow_n(iow_n));
   initial forever #2 clk_sys = ~clk_sys;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 reset_n = 1;
      for (int i = 0; i < 4000; i++) begin
         s = dout[1:0];
         ex = {(rate == 2'h0 || rate == 2'h3) ^ cfg[5], r[13:12] == 2'h1 && r[14],
            !seen ? 2'h3 : cfg[7] ? ~s : s == 2'h0 ? 2'h2 : s == 2'h1 ? 2'h1 : 2'h3,
            !seen ? 2'h0 : cfg[7] ? {1'b0, |dout[7:4]} : dout[5:4], rate[0], r[15],
            !ack_n && !ior_n, !ack_n && !iow_n};
         @(posedge clk_sys);
         #1 n_compared++;
         if (q !== ex) begin
            err_total++;
            $display("FAIL %0t got %h exp %h", $time, q, ex);
         end
         if (r[0] & r[1]) {seen, dout} = {1'b1, r[15:8]};
         if (r[2] & r[3] & r[4]) cfg = r[15:8];
         if (r[6] & r[7]) rate = r[11:10]; else if (r[5]) rate = r[9:8];
         r = lfsr(r);
      end
      $display("random test done");
      report_and_stop();
   end
endmodule // fdo_drive_outputs_tb
